// >>> rtl/phsp_pkg.sv
package phsp_pkg;

  // Register bus shape
  localparam int PHSP_AW = 4;
  localparam int PHSP_DW = 8;

  // Register offsets on the plain register port
  localparam logic [3:0] PHSP_OFF_CTRL = 4'h0;
  localparam logic [3:0] PHSP_OFF_DPINS = 4'h1;
  localparam logic [3:0] PHSP_OFF_DLATCH = 4'h2;
  localparam logic [3:0] PHSP_OFF_DDIR = 4'h3;
  localparam logic [3:0] PHSP_OFF_EPINS = 4'h4;
  localparam logic [3:0] PHSP_OFF_EDIR = 4'h5;
  localparam logic [3:0] PHSP_OFF_IRQF = 4'h6;
  localparam logic [3:0] PHSP_OFF_IRQE = 4'h7;
  localparam logic [3:0] PHSP_OFF_IRQP = 4'h8;

  // Control and status field positions
  localparam int PHSP_BIT_IBF = 7;
  localparam int PHSP_BIT_OBF = 6;
  localparam int PHSP_BIT_INPUT_BUFFER_OVERRUN = 5;
  localparam int PHSP_BIT_EN = 4;

  // Host port bit in the flag, enable and priority registers
  localparam int PHSP_BIT_IRQ = 7;

  // Control pin positions on the second port
  localparam int PHSP_PIN_RD = 0;
  localparam int PHSP_PIN_WR = 1;
  localparam int PHSP_PIN_CS = 2;

  // Values after reset, and the all-output enable pattern
  localparam logic [7:0] PHSP_RST_LATCH = 8'h00;
  localparam logic [7:0] PHSP_RST_DIR = 8'hFF;
  localparam logic [7:0] PHSP_RST_ZERO = 8'h00;
  localparam logic [7:0] PHSP_ALL_OUT = 8'hFF;

  // Synchroniser depth in clock cycles
  localparam int PHSP_SYNC_STAGES = 2;

  // Host transfer sequencer states
  typedef enum logic [1:0] {
    PHSP_IDLE = 2'b00,
    PHSP_WRITE = 2'b01,
    PHSP_READ = 2'b10
  } phsp_state_t;

endpackage : phsp_pkg

// >>> rtl/phsp_sync.sv
`timescale 1ns/1ns
module phsp_sync
  import phsp_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Asynchronous inputs and their synchronised copies
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta;

  // First stage is read by the second stage only
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta <= '0;
    end else begin
      meta <= d_i;
    end
  end

  // Second stage is the only copy the logic may read
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q_o <= '0;
    end else begin
      q_o <= meta;
    end
  end

endmodule : phsp_sync

// >>> rtl/phsp_host_port.sv
`timescale 1ns/1ns
module phsp_host_port
  import phsp_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Register port
  input wire logic [PHSP_AW-1:0] addr_i,
  input wire logic [PHSP_DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [PHSP_DW-1:0] rdata_o,
  // Operating mode, high in microcontroller mode
  input wire logic mcu_mode_i,
  // Data port pins
  input wire logic [7:0] host_data_in_i,
  output logic [7:0] host_data_out_o,
  output logic [7:0] host_data_oe_o,
  // Control port pins
  input wire logic [7:0] ctrl_pins_in_i,
  output logic [7:0] ctrl_pins_out_o,
  output logic [7:0] ctrl_pins_oe_o,
  // Interrupt request
  output logic irq_o,
  output logic irq_high_o
);

  // Synchronised pin copies
  logic [16:0] sync_q;
  logic [7:0] data_s;
  logic [7:0] ctrl_s;
  logic mode_s;

  // Software visible state
  logic host_port_enable;
  logic input_buffer_full;
  logic output_buffer_full;
  logic input_buffer_overrun;
  logic [7:0] host_data_latch;
  logic [7:0] host_data_direction;
  logic [7:0] ctrl_pins_latch;
  logic [7:0] control_pins_direction;
  logic [7:0] host_input_word;
  logic host_port_irq_flag;
  logic host_port_irq_enable;
  logic host_port_irq_priority;

  // Sequencer
  phsp_state_t state;
  phsp_state_t next_state;
  logic write_end;
  logic read_end;

  // Decoded strobes and conditions
  logic port_on;
  logic cs_low;
  logic wr_low;
  logic rd_low;
  logic cpu_wr_ctrl;
  logic cpu_wr_data;
  logic cpu_rd_inbuf;
  logic cpu_wr_irqf;
  logic [7:0] next_rdata;

  // Address match, used by every decode below
  function automatic logic hit(input logic [PHSP_AW-1:0] a, input logic [PHSP_AW-1:0] off);
    hit = (a == off);
  endfunction : hit

  // All pins arrive from outside the clock domain
  phsp_sync #(
    .WIDTH(17)
  ) u_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .d_i({mcu_mode_i, ctrl_pins_in_i, host_data_in_i}),
    .q_o(sync_q)
  );

  // Synchronisers clear to zero, so strobes look low for two cycles after reset;
  // harmless, because the enable bit clears too and gates the sequencer
  assign data_s = sync_q[7:0];
  assign ctrl_s = sync_q[15:8];
  assign mode_s = sync_q[16];

  // Slave port needs the enable bit and microcontroller mode
  assign port_on = host_port_enable & mode_s;

  // Active-low strobes taken from the control pins
  assign cs_low = ~ctrl_s[PHSP_PIN_CS];
  assign wr_low = ~ctrl_s[PHSP_PIN_WR];
  assign rd_low = ~ctrl_s[PHSP_PIN_RD];

  // Register port decode
  assign cpu_wr_ctrl = wr_i & hit(addr_i, PHSP_OFF_CTRL);
  assign cpu_wr_data = wr_i & (hit(addr_i, PHSP_OFF_DPINS) | hit(addr_i, PHSP_OFF_DLATCH));
  assign cpu_rd_inbuf = rd_i & port_on & hit(addr_i, PHSP_OFF_DPINS);
  assign cpu_wr_irqf = wr_i & hit(addr_i, PHSP_OFF_IRQF);

  // A transfer cut by disable or mode loss ends with no status or flag update
  // Host transfer sequencer; write wins if both strobes fall together
  always_comb begin
    next_state = state;
    write_end = 1'b0;
    read_end = 1'b0;
    case (state)
      PHSP_IDLE: begin
        if (port_on && cs_low && wr_low) begin
          next_state = PHSP_WRITE;
        end else if (port_on && cs_low && rd_low) begin
          next_state = PHSP_READ;
        end
      end
      PHSP_WRITE: begin
        if (!port_on) begin
          next_state = PHSP_IDLE;
        end else if (!cs_low || !wr_low) begin
          next_state = PHSP_IDLE;
          write_end = 1'b1;
        end
      end
      PHSP_READ: begin
        if (!port_on) begin
          next_state = PHSP_IDLE;
        end else if (!cs_low || !rd_low) begin
          next_state = PHSP_IDLE;
          read_end = 1'b1;
        end
      end
      default: begin
        next_state = PHSP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= PHSP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Host word sampled while both strobes stay low; the end sample may be stale
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      host_input_word <= PHSP_RST_ZERO;
    end else if (next_state == PHSP_WRITE) begin
      host_input_word <= data_s;
    end
  end

  // Input-full: set at write end, cleared by CPU read, set wins
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      input_buffer_full <= 1'b0;
    end else if (write_end) begin
      input_buffer_full <= 1'b1;
    end else if (cpu_rd_inbuf) begin
      input_buffer_full <= 1'b0;
    end
  end

  // Overrun is sticky; software write may clear it, hardware set wins
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      input_buffer_overrun <= 1'b0;
    end else if (write_end && input_buffer_full) begin
      input_buffer_overrun <= 1'b1;
    end else if (cpu_wr_ctrl) begin
      input_buffer_overrun <= wdata_i[PHSP_BIT_INPUT_BUFFER_OVERRUN];
    end
  end

  // Output-full: CPU write in slave mode sets it unless a host read is running
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      output_buffer_full <= 1'b0;
    end else if (cpu_wr_data && port_on && state != PHSP_READ) begin
      output_buffer_full <= 1'b1;
    end else if (read_end) begin
      output_buffer_full <= 1'b0;
    end
  end

  // Mode select bit
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      host_port_enable <= 1'b0;
    end else if (cpu_wr_ctrl) begin
      host_port_enable <= wdata_i[PHSP_BIT_EN];
    end
  end

  // Data latch, shared by both data offsets
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      host_data_latch <= PHSP_RST_LATCH;
    end else if (cpu_wr_data) begin
      host_data_latch <= wdata_i;
    end
  end

  // Direction registers and control pin latch; inputs after reset
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      host_data_direction <= PHSP_RST_DIR;
      control_pins_direction <= PHSP_RST_DIR;
      ctrl_pins_latch <= PHSP_RST_LATCH;
    end else if (wr_i) begin
      if (hit(addr_i, PHSP_OFF_DDIR)) begin
        host_data_direction <= wdata_i;
      end else if (hit(addr_i, PHSP_OFF_EDIR)) begin
        control_pins_direction <= wdata_i;
      end else if (hit(addr_i, PHSP_OFF_EPINS)) begin
        ctrl_pins_latch <= wdata_i;
      end
    end
  end

  // Port flag: set by either transfer end, write one clears, set wins
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      host_port_irq_flag <= 1'b0;
    end else if (write_end || read_end) begin
      host_port_irq_flag <= 1'b1;
    end else if (cpu_wr_irqf && wdata_i[PHSP_BIT_IRQ]) begin
      host_port_irq_flag <= 1'b0;
    end
  end

  // Interrupt mask and priority
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      host_port_irq_enable <= 1'b0;
      host_port_irq_priority <= 1'b0;
    end else if (wr_i) begin
      if (hit(addr_i, PHSP_OFF_IRQE)) begin
        host_port_irq_enable <= wdata_i[PHSP_BIT_IRQ];
      end else if (hit(addr_i, PHSP_OFF_IRQP)) begin
        host_port_irq_priority <= wdata_i[PHSP_BIT_IRQ];
      end
    end
  end

  // Interrupt outputs, registered so they lag the flag by one cycle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_o <= 1'b0;
      irq_high_o <= 1'b0;
    end else begin
      irq_o <= host_port_irq_flag & host_port_irq_enable;
      irq_high_o <= host_port_irq_flag & host_port_irq_enable & host_port_irq_priority;
    end
  end

  // New CPU data reaches the pins one cycle later, even in mid-read
  // Data pins: in slave mode driven only during a host read; otherwise set by the direction register
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      host_data_out_o <= PHSP_RST_LATCH;
      host_data_oe_o <= PHSP_RST_ZERO;
    end else begin
      host_data_out_o <= cpu_wr_data ? wdata_i : host_data_latch;
      if (port_on) begin
        host_data_oe_o <= (next_state == PHSP_READ) ? PHSP_ALL_OUT : PHSP_RST_ZERO;
      end else begin
        host_data_oe_o <= ~host_data_direction;
      end
    end
  end

  // Control pins; strobe pins never driven in slave mode, whatever firmware set
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_pins_out_o <= PHSP_RST_LATCH;
      ctrl_pins_oe_o <= PHSP_RST_ZERO;
    end else begin
      ctrl_pins_out_o <= ctrl_pins_latch;
      if (port_on) begin
        ctrl_pins_oe_o <= {~control_pins_direction[7:3], 3'h0};
      end else begin
        ctrl_pins_oe_o <= ~control_pins_direction;
      end
    end
  end

  // Reading offset 1 in slave mode also empties the input buffer
  // Read mux; unmapped offsets and reserved bits read zero
  always_comb begin
    next_rdata = PHSP_RST_ZERO;
    if (hit(addr_i, PHSP_OFF_CTRL)) begin
      next_rdata = {input_buffer_full, output_buffer_full, input_buffer_overrun, host_port_enable, 4'h0};
    end else if (hit(addr_i, PHSP_OFF_DPINS)) begin
      next_rdata = port_on ? host_input_word : data_s;
    end else if (hit(addr_i, PHSP_OFF_DLATCH)) begin
      next_rdata = host_data_latch;
    end else if (hit(addr_i, PHSP_OFF_DDIR)) begin
      next_rdata = host_data_direction;
    end else if (hit(addr_i, PHSP_OFF_EPINS)) begin
      next_rdata = ctrl_s;
    end else if (hit(addr_i, PHSP_OFF_EDIR)) begin
      next_rdata = control_pins_direction;
    end else if (hit(addr_i, PHSP_OFF_IRQF)) begin
      next_rdata = {host_port_irq_flag, 7'h00};
    end else if (hit(addr_i, PHSP_OFF_IRQE)) begin
      next_rdata = {host_port_irq_enable, 7'h00};
    end else if (hit(addr_i, PHSP_OFF_IRQP)) begin
      next_rdata = {host_port_irq_priority, 7'h00};
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= PHSP_RST_ZERO;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= PHSP_RST_ZERO;
    end
  end

endmodule : phsp_host_port

// >>> verification/phsp_host_port_properties.sv
`timescale 1ns/1ns
module phsp_host_port_checker
  import phsp_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Register port
  input wire logic [PHSP_AW-1:0] addr_i,
  input wire logic [PHSP_DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [PHSP_DW-1:0] rdata_o,
  // Pins and interrupts
  input wire logic mcu_mode_i,
  input wire logic [7:0] host_data_in_i,
  input wire logic [7:0] host_data_out_o,
  input wire logic [7:0] host_data_oe_o,
  input wire logic [7:0] ctrl_pins_in_i,
  input wire logic [7:0] ctrl_pins_out_o,
  input wire logic [7:0] ctrl_pins_oe_o,
  input wire logic irq_o,
  input wire logic irq_high_o
);
  logic en;
  logic irq_en;
  logic [2:0] act_cnt;
  wire logic act = act_cnt == 3'h7;
  wire logic rd_ctrl = rd_i && addr_i == PHSP_OFF_CTRL;
  wire logic rd_on = !ctrl_pins_in_i[PHSP_PIN_RD] && !ctrl_pins_in_i[PHSP_PIN_CS];
  wire logic wr_on = !ctrl_pins_in_i[PHSP_PIN_WR] && !ctrl_pins_in_i[PHSP_PIN_CS];
  // Enable bits snooped from the bus, since the body is hidden
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      en <= 1'b0;
      irq_en <= 1'b0;
    end else if (wr_i && addr_i == PHSP_OFF_CTRL) begin
      en <= wdata_i[PHSP_BIT_EN];
    end else if (wr_i && addr_i == PHSP_OFF_IRQE) begin
      irq_en <= wdata_i[PHSP_BIT_IRQ];
    end
  end
  // Settle count, so the mode synchroniser has caught up
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) act_cnt <= 3'h0;
    else if (!(en && mcu_mode_i)) act_cnt <= 3'h0;
    else if (!act) act_cnt <= act_cnt + 3'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_read_held; (act && rd_on && !wr_on) [*5]; endsequence
  sequence s_write_held; (act && wr_on) [*5]; endsequence
  a_drive_on_read: assert property (s_read_held |-> host_data_oe_o == PHSP_ALL_OUT)
    else $error("data pins not driven in host read");
  a_release_after_read: assert property (s_read_held ##1 !rd_on |-> ##[2:5] host_data_oe_o == 8'h00)
    else $error("data pins kept driven after host read");
  a_idle_released: assert property ((act && !rd_on) [*6] |-> host_data_oe_o == 8'h00)
    else $error("data pins driven outside host read");
  a_write_end_irq: assert property (s_write_held ##1 (!wr_on && irq_en) |-> ##[2:6] irq_o)
    else $error("no interrupt after host write");
  a_irq_needs_enable: assert property (irq_o |-> irq_en || $past(irq_en))
    else $error("interrupt while disabled");
  a_priority_subset: assert property (irq_high_o |-> irq_o)
    else $error("high priority request without request");
  a_read_data_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside answer cycle");
  a_ctrl_fields: assert property ($past(rd_ctrl) |-> rdata_o[3:0] == 4'h0
    && rdata_o[PHSP_BIT_EN] == $past(en))
    else $error("control register fields wrong");
  a_strobe_pins_in: assert property (act |-> ctrl_pins_oe_o[2:0] == 3'b000)
    else $error("strobe pins driven in slave mode");
endmodule : phsp_host_port_checker

bind phsp_host_port phsp_host_port_checker chk_u (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .mcu_mode_i(mcu_mode_i),
  .host_data_in_i(host_data_in_i), .host_data_out_o(host_data_out_o), .host_data_oe_o(host_data_oe_o),
  .ctrl_pins_in_i(ctrl_pins_in_i), .ctrl_pins_out_o(ctrl_pins_out_o), .ctrl_pins_oe_o(ctrl_pins_oe_o),
  .irq_o(irq_o), .irq_high_o(irq_high_o));

// >>> verification/phsp_host_cpu.sv
`timescale 1ns/1ns
module phsp_host_cpu (
  // Pacing clock
  input wire logic clk_i,
  // Device side of the data pins
  input wire logic [7:0] dev_out_i,
  input wire logic [7:0] dev_oe_i,
  // Resolved pins; strobes are select, write, read, active low
  output logic [7:0] bus_o,
  output logic [2:0] strobe_n_o
);
  logic [7:0] drv = 8'h00;
  logic drv_en = 1'b0;
  logic [7:0] last = 8'h00;
  initial strobe_n_o = 3'b111;
  // Undriven bits flip each cycle, no stale value
  always_ff @(posedge clk_i) last <= bus_o;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      bus_o[i] = dev_oe_i[i] ? dev_out_i[i] : (drv_en ? drv[i] : ~last[i]);
    end
  end
  // Data held past strobe rise, to outlast the synchroniser
  task automatic host_write(input logic [7:0] d);
    @(posedge clk_i);
    drv <= d;
    drv_en <= 1'b1;
    strobe_n_o <= 3'b001;
    repeat (6) @(posedge clk_i);
    strobe_n_o <= 3'b111;
    repeat (4) @(posedge clk_i);
    drv_en <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : host_write
  // Pins sampled just before the strobes lift
  task automatic host_read(output logic [7:0] q);
    @(posedge clk_i);
    strobe_n_o <= 3'b010;
    repeat (7) @(posedge clk_i);
    @(negedge clk_i);
    q = bus_o;
    @(posedge clk_i);
    strobe_n_o <= 3'b111;
    repeat (8) @(posedge clk_i);
  endtask : host_read
endmodule : phsp_host_cpu

// >>> verification/tb.sv
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module tb
  import phsp_pkg::*;
;
  typedef struct {logic [3:0] a; logic [7:0] w; logic [7:0] e;} phsp_tb_row_t;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [PHSP_AW-1:0] addr_i = '0;
  logic [PHSP_DW-1:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic mcu_mode_i = 1'b1;
  logic [PHSP_DW-1:0] rdata_o;
  logic [7:0] d_out, d_oe, bus, c_out, c_oe, q;
  logic [2:0] strb_n;
  logic irq_o, irq_high_o;
  int n_fail = 0;
  int n_compared = 0;
  // Write then read back; flags read-only bits and unmapped space
  phsp_tb_row_t rows[10] = '{'{4'h0, 8'hFF, 8'h30}, '{4'h0, 8'h00, 8'h00}, '{4'h2, 8'hA5, 8'hA5},
    '{4'h3, 8'h5A, 8'h5A}, '{4'h5, 8'h3C, 8'h3C}, '{4'h4, 8'h96, 8'h07}, '{4'h7, 8'hFF, 8'h80},
    '{4'h8, 8'hFF, 8'h80},
    '{4'h6, 8'hFF, 8'h00}, '{4'hF, 8'hFF, 8'h00}};
  always #10 clk_i = ~clk_i;
  phsp_host_port dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .mcu_mode_i(mcu_mode_i), .host_data_in_i(bus), .host_data_out_o(d_out),
    .host_data_oe_o(d_oe), .ctrl_pins_in_i({5'h00, strb_n}), .ctrl_pins_out_o(c_out), .ctrl_pins_oe_o(c_oe),
    .irq_o(irq_o), .irq_high_o(irq_high_o));
  phsp_host_cpu host_u (.clk_i(clk_i), .dev_out_i(d_out), .dev_oe_i(d_oe), .bus_o(bus), .strobe_n_o(strb_n));
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : reg_wr
  // Answer stands only in the cycle after the strobe
  task automatic expect_rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 `CHK(rdata_o, e)
  endtask : expect_rd
  task automatic tally_and_finish;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic wait_irq;
    int k = 0;
    while (irq_o !== 1'b1 && k < 40) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 40) begin
      $display("wrong value at %0t: no interrupt", $time);
      n_fail++;
      tally_and_finish;
    end
  endtask : wait_irq
  initial begin
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    expect_rd(PHSP_OFF_CTRL, PHSP_RST_ZERO);
    expect_rd(PHSP_OFF_DDIR, PHSP_RST_DIR);
    expect_rd(PHSP_OFF_EDIR, PHSP_RST_DIR);
    `CHK(d_oe, 8'h00)
    for (int i = 0; i < 10; i++) begin
      reg_wr(rows[i].a, rows[i].w);
      expect_rd(rows[i].a, rows[i].e);
    end
    // Plain port mode: direction and latch reach the pins
    `CHK(d_oe, 8'hA5)
    `CHK(d_out, 8'hA5)
    `CHK(c_oe, 8'hC3)
    `CHK(c_out, 8'h96)
    reg_wr(PHSP_OFF_CTRL, 8'h10);
    repeat (4) @(posedge clk_i);
    `CHK(c_oe, 8'hC0)
    `CHK(d_oe, 8'h00)
    // Two host writes with no CPU read of the input buffer between
    host_u.host_write(8'h3C);
    wait_irq;
    `CHK(irq_high_o, 1'b1)
    expect_rd(PHSP_OFF_CTRL, 8'h90);
    host_u.host_write(8'hC3);
    expect_rd(PHSP_OFF_CTRL, 8'hB0);
    expect_rd(PHSP_OFF_DPINS, 8'hC3);
    expect_rd(PHSP_OFF_CTRL, 8'h30);
    reg_wr(PHSP_OFF_CTRL, 8'h10);
    expect_rd(PHSP_OFF_CTRL, 8'h10);
    reg_wr(PHSP_OFF_IRQF, 8'h80);
    repeat (2) @(posedge clk_i);
    `CHK(irq_o, 1'b0)
    // Host read of a CPU word, then masking
    reg_wr(PHSP_OFF_DPINS, 8'h5A);
    expect_rd(PHSP_OFF_CTRL, 8'h50);
    host_u.host_read(q);
    `CHK(q, 8'h5A)
    expect_rd(PHSP_OFF_CTRL, 8'h10);
    expect_rd(PHSP_OFF_IRQF, 8'h80);
    // Low priority keeps the request but drops the high one
    reg_wr(PHSP_OFF_IRQP, 8'h00);
    repeat (2) @(posedge clk_i);
    `CHK(irq_o, 1'b1)
    `CHK(irq_high_o, 1'b0)
    reg_wr(PHSP_OFF_IRQE, 8'h00);
    repeat (2) @(posedge clk_i);
    `CHK(irq_o, 1'b0)
    reg_wr(PHSP_OFF_IRQF, 8'h80);
    // CPU write lands in the middle of a host read
    fork
      host_u.host_read(q);
      begin
        repeat (4) @(posedge clk_i);
        reg_wr(PHSP_OFF_DPINS, 8'h77);
      end
    join
    `CHK(q, 8'h77)
    expect_rd(PHSP_OFF_CTRL, 8'h10);
    reg_wr(PHSP_OFF_IRQF, 8'h80);
    // Outside controller mode the host is ignored
    @(posedge clk_i);
    mcu_mode_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    host_u.host_write(8'h11);
    expect_rd(PHSP_OFF_CTRL, 8'h10);
    expect_rd(PHSP_OFF_IRQF, 8'h00);
    tally_and_finish;
  end
endmodule : tb
